/* File: verilog/pmt_timer.sv */
// periodic modulo tick timer with axi4-lite register access
// What this block does
// - 16-bit up-counter, 16-bit compare limit, source selector, binary and decimal prescaler.
// - reset stops counter at zero, clears limit, prescaler off.
// - source select resets to external crystal oscillator, code 00.
// - prescale select 000 keeps prescaler off; nonzero starts counting.
// - source codes: 00 crystal, 01 low power, 10 internal reference, 11 bus.
// - writing a different source select clears prescaler and counter.
// - writing a different prescale select clears prescaler and counter.
// - sources 00/10: codes 001..111 divide by 1,2,4,8,16,32,64.
// - sources 01/11: codes 001..111 divide by 128..2048,100,1000.
// - counter steps per prescaler tick, wraps to zero after equalling limit.
// - match flag sets when counter moves from limit to zero.
// - written limit is held until overflow or nonzero prescale select.
// - interrupt request while match flag and interrupt enable are both set.
// - writing one to match flag clears flag and request.
// - with output enable set, output pin inverts at every overflow.
// - pin toggles in the same step as the flag sets.
// - writing zero to match flag leaves it unchanged.
// - limit of zero sets the flag on every prescaler tick.
// - count is read-only; software reads all 16 bits in one access.
`timescale 1ns/100ps
module pmt_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_osc_clk,
  input wire logic low_power_osc_clk,
  input wire logic int_ref_clk,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic match_irq,
  output logic toggle_out
);

  // last prescaler count (ratio minus one) per source group and code; 2048 fits this way
  function automatic logic [pmt_pkg::div_w-1:0] div_ratio(input logic [1:0] src, input logic [2:0] ps);
    logic [pmt_pkg::div_w-1:0] r;
    r = 11'h000;
    if (src[0] == 1'b0) begin
      case (ps)
        3'h1: r = 11'h000;
        3'h2: r = 11'h001;
        3'h3: r = 11'h003;
        3'h4: r = 11'h007;
        3'h5: r = 11'h00F;
        3'h6: r = 11'h01F;
        3'h7: r = 11'h03F;
        default: r = 11'h000;
      endcase
    end else begin
      case (ps)
        3'h1: r = 11'h07F;
        3'h2: r = 11'h0FF;
        3'h3: r = 11'h1FF;
        3'h4: r = 11'h3FF;
        3'h5: r = 11'h7FF;
        3'h6: r = 11'h063;
        3'h7: r = 11'h3E7;
        default: r = 11'h000;
      endcase
    end
    return r;
  endfunction

  // register decode
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // source clock synchronisers
  logic [2:0] src_pin;
  logic [2:0] src_s1_ff;
  logic [2:0] src_s2_ff;
  logic [2:0] src_s3_ff;
  logic [2:0] src_lvl_ff;
  logic [2:0] src_rise;
  assign src_pin = {int_ref_clk, low_power_osc_clk, ext_osc_clk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // three flops; level accepted when stages two and three agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          src_s1_ff[gi] <= 1'b0;
          src_s2_ff[gi] <= 1'b0;
          src_s3_ff[gi] <= 1'b0;
          src_lvl_ff[gi] <= 1'b0;
        end else begin
          src_s1_ff[gi] <= src_pin[gi];
          src_s2_ff[gi] <= src_s1_ff[gi];
          src_s3_ff[gi] <= src_s2_ff[gi];
          if (src_s2_ff[gi] == src_s3_ff[gi]) begin
            src_lvl_ff[gi] <= src_s3_ff[gi];
          end
        end
      end
      assign src_rise[gi] = src_s2_ff[gi] & src_s3_ff[gi] & ~src_lvl_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // control state
  pmt_pkg::pmt_ctrl_t ctrl_ff;
  logic [15:0] limit_wr_ff;
  logic [15:0] limit_act_ff;
  logic [15:0] count_ff;
  logic [pmt_pkg::div_w-1:0] pre_ff;
  logic match_flag_ff;
  logic toggle_ff;

  // bus write capture
  logic [11:0] aw_addr_ff;
  logic aw_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_full_ff;
  logic do_write;
  logic wr_ctrl;
  logic wr_limit;
  logic [1:0] nxt_source;
  logic [2:0] nxt_prescale;
  logic cfg_change;
  logic src_edge;
  logic pre_tick;
  logic overflow;

  assign do_write = aw_full_ff & w_full_ff & ~s_axi_bvalid;
  assign wr_ctrl = do_write & addr_is(aw_addr_ff, pmt_pkg::ctrl_status_off);
  assign wr_limit = do_write & addr_is(aw_addr_ff, pmt_pkg::compare_limit_off);
  assign nxt_source = w_strb_ff[1] ? w_data_ff[pmt_pkg::source_lsb +: 2] : ctrl_ff.source_select;
  assign nxt_prescale = w_strb_ff[1] ? w_data_ff[pmt_pkg::prescale_lsb +: 3] : ctrl_ff.prescale_select;
  assign cfg_change = wr_ctrl & ((nxt_source != ctrl_ff.source_select)
    | (nxt_prescale != ctrl_ff.prescale_select));

  // source routing
  always_comb begin
    case (ctrl_ff.source_select)
      pmt_pkg::src_ext_osc: src_edge = src_rise[0];
      pmt_pkg::src_low_power: src_edge = src_rise[1];
      pmt_pkg::src_int_ref: src_edge = src_rise[2];
      pmt_pkg::src_bus: src_edge = 1'b1;
      default: src_edge = 1'b0;
    endcase
  end

  assign pre_tick = src_edge & (ctrl_ff.prescale_select != pmt_pkg::prescale_off)
    & (pre_ff == div_ratio(ctrl_ff.source_select, ctrl_ff.prescale_select));
  assign overflow = pre_tick & (count_ff == limit_act_ff) & ~cfg_change;

  // control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff.source_select <= pmt_pkg::src_ext_osc;
      ctrl_ff.prescale_select <= pmt_pkg::prescale_off;
      ctrl_ff.match_irq_enable <= 1'b0;
      ctrl_ff.toggle_output_enable <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_ff.source_select <= nxt_source;
      ctrl_ff.prescale_select <= nxt_prescale;
      if (w_strb_ff[0]) begin
        ctrl_ff.match_irq_enable <= w_data_ff[pmt_pkg::irq_enable_bit];
        ctrl_ff.toggle_output_enable <= w_data_ff[pmt_pkg::toggle_en_bit];
      end
    end
  end

  // prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_change || ctrl_ff.prescale_select == pmt_pkg::prescale_off) begin
      pre_ff <= '0;
    end else if (pre_tick) begin
      pre_ff <= '0;
    end else if (src_edge) begin
      pre_ff <= pre_ff + 11'h001;
    end
  end

  // main counter
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_change) begin
      count_ff <= pmt_pkg::count_reset;
    end else if (overflow) begin
      count_ff <= pmt_pkg::count_reset;
    end else if (pre_tick) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // compare limit: written copy and active copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_wr_ff <= pmt_pkg::limit_reset;
      limit_act_ff <= pmt_pkg::limit_reset;
    end else begin
      if (wr_limit) begin
        if (w_strb_ff[0]) limit_wr_ff[7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) limit_wr_ff[15:8] <= w_data_ff[15:8];
      end
      if (overflow || (wr_ctrl && nxt_prescale != pmt_pkg::prescale_off)) begin
        limit_act_ff <= limit_wr_ff;
      end
    end
  end

  // match flag, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_flag_ff <= 1'b0;
    end else if (overflow) begin
      match_flag_ff <= 1'b1;
    end else if (wr_ctrl && w_strb_ff[0] && w_data_ff[pmt_pkg::match_flag_bit]) begin
      match_flag_ff <= 1'b0;
    end
  end

  // output pin toggle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_ff <= 1'b0;
    end else if (overflow && ctrl_ff.toggle_output_enable) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  assign match_irq = match_flag_ff & ctrl_ff.match_irq_enable;
  assign toggle_out = toggle_ff;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  assign s_axi_awready = ~aw_full_ff;
  assign s_axi_wready = ~w_full_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && !aw_full_ff) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && !w_full_ff) begin
      w_full_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end
  end

  // write response; count register silently ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmt_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl || wr_limit || addr_is(aw_addr_ff, pmt_pkg::tick_count_off))
        ? pmt_pkg::resp_okay : pmt_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pmt_pkg::resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= pmt_pkg::resp_okay;
      s_axi_rdata <= '0;
      if (addr_is(s_axi_araddr, pmt_pkg::ctrl_status_off)) begin
        s_axi_rdata[pmt_pkg::source_lsb +: 2] <= ctrl_ff.source_select;
        s_axi_rdata[pmt_pkg::prescale_lsb +: 3] <= ctrl_ff.prescale_select;
        s_axi_rdata[pmt_pkg::match_flag_bit] <= match_flag_ff;
        s_axi_rdata[pmt_pkg::irq_enable_bit] <= ctrl_ff.match_irq_enable;
        s_axi_rdata[pmt_pkg::toggle_en_bit] <= ctrl_ff.toggle_output_enable;
      end else if (addr_is(s_axi_araddr, pmt_pkg::compare_limit_off)) begin
        s_axi_rdata[15:0] <= limit_wr_ff;
      end else if (addr_is(s_axi_araddr, pmt_pkg::tick_count_off)) begin
        s_axi_rdata[15:0] <= count_ff;
      end else begin
        s_axi_rresp <= pmt_pkg::resp_slverr;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: verilog/pmt_pkg.sv */
// constants and types for the periodic modulo tick timer
package pmt_pkg;
  // register byte offsets
  localparam logic [11:0] ctrl_status_off = 12'h000;
  localparam logic [11:0] compare_limit_off = 12'h004;
  localparam logic [11:0] tick_count_off = 12'h008;
  localparam int addr_w = 12;
  // control/status field positions
  localparam int match_flag_bit = 7;
  localparam int irq_enable_bit = 6;
  localparam int toggle_en_bit = 4;
  localparam int prescale_lsb = 8;
  localparam int source_lsb = 14;
  // encodings and reset values
  localparam logic [1:0] src_ext_osc = 2'h0;
  localparam logic [1:0] src_low_power = 2'h1;
  localparam logic [1:0] src_int_ref = 2'h2;
  localparam logic [1:0] src_bus = 2'h3;
  localparam logic [2:0] prescale_off = 3'h0;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] limit_reset = 16'h0000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam int div_w = 11;
  // software-visible control fields
  typedef struct packed {
    logic [1:0] source_select;
    logic [2:0] prescale_select;
    logic match_irq_enable;
    logic toggle_output_enable;
  } pmt_ctrl_t;
endpackage

/* File: verification/pmt_timer_checker.sv */
// bus and output assertions for the tick timer
`timescale 1ns/100ps
module pmt_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic match_irq,
  input wire logic toggle_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // register bus answers
  property p_wr_ans;
    !s_axi_bvalid && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while busy");
  property p_w_block; $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready); endproperty
  a_w_block: assert property (p_w_block) else $error("answer without held write");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == pmt_pkg::resp_slverr |-> s_axi_rdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  ////////////////////////////////////////////////////////////////////////////////
  // timer outputs
  property p_irq_clr; $fell(match_irq) |-> $rose(s_axi_bvalid); endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("request dropped without write");
  property p_rst_quiet; $rose(aresetn) |-> !toggle_out && !match_irq && !s_axi_bvalid; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_tgl_gap; $changed(toggle_out) && $past(match_irq) |-> match_irq || $rose(s_axi_bvalid); endproperty
  a_tgl_gap: assert property (p_tgl_gap) else $error("request dropped at toggle");
endmodule

/* File: verification/pmt_timer_tb_top.sv */
// self-checking bench for the periodic modulo tick timer
`timescale 1ns/100ps
module pmt_timer_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, ext_osc_clk = 1'b0, low_power_osc_clk = 1'b0, int_ref_clk = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, match_irq, toggle_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  int failures = 0, n_compared = 0, cyc = 0, t0;
  int bin_div [7] = '{1, 2, 4, 8, 16, 32, 64};
  int dec_div [7] = '{128, 256, 512, 1024, 2048, 100, 1000};
  int src_per [4] = '{8, 6, 10, 1};
  pmt_timer i_pmt_timer (.aclk, .aresetn, .ext_osc_clk, .low_power_osc_clk, .int_ref_clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .match_irq, .toggle_out);
  ////////////////////////////////////////////////////////////////////////////////
  // clocks: source edges land on falling bus clock edges
  always #5 aclk = ~aclk;
  always #40 ext_osc_clk = ~ext_osc_clk;
  always #30 low_power_osc_clk = ~low_power_osc_clk;
  always #50 int_ref_clk = ~int_ref_clk;
  always @(posedge aclk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks and checks
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk("read data", exp, d);
  endtask
  task wait_tgl;
    logic t;
    t = toggle_out;
    do @(posedge aclk); while (toggle_out === t);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] src, input logic [2:0] ps);
    ctl = 32'h0000_0000;
    ctl[pmt_pkg::source_lsb +: 2] = src;
    ctl[pmt_pkg::prescale_lsb +: 3] = ps;
    ctl[pmt_pkg::irq_enable_bit] = 1'b1;
    ctl[pmt_pkg::toggle_en_bit] = 1'b1;
  endfunction
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(pmt_pkg::ctrl_status_off, 32'h0000_0000);
    rchk(pmt_pkg::compare_limit_off, 32'h0000_0000);
    rchk(pmt_pkg::tick_count_off, 32'h0000_0000);
    rd(12'h00C);
    chk("unmapped read resp", 32'(pmt_pkg::resp_slverr), 32'(r));
    wr(12'h00C, 32'hFFFF_FFFF);
    chk("unmapped write resp", 32'(pmt_pkg::resp_slverr), 32'(r));
    wr(pmt_pkg::tick_count_off, 32'h0000_1234);
    rchk(pmt_pkg::tick_count_off, 32'h0000_0000);
    wr(pmt_pkg::compare_limit_off, 32'hABCD_0002);
    rchk(pmt_pkg::compare_limit_off, 32'h0000_0002);
    // bus source, divide 128, wrap after limit 2
    wr(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h1));
    wait_tgl;
    chk("request with toggle", 32'h1, 32'(match_irq));
    t0 = cyc;
    wait_tgl;
    chk("wrap period", 32'd384, 32'(cyc - t0));
    wr(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h1));
    rchk(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h1) | 32'h0000_0080);
    wr(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h1) | 32'h0000_0080);
    chk("request after clear", 32'h0, 32'(match_irq));
    rchk(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h1));
    // config changes restart the count
    wr(pmt_pkg::compare_limit_off, 32'h0000_FFFF);
    wr(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h2));
    rchk(pmt_pkg::tick_count_off, 32'h0000_0000);
    repeat (800) @(posedge aclk);
    rchk(pmt_pkg::tick_count_off, 32'h0000_0003);
    wr(pmt_pkg::ctrl_status_off, ctl(2'h1, 3'h2));
    rchk(pmt_pkg::tick_count_off, 32'h0000_0000);
    // every source and prescale code with limit zero
    wr(pmt_pkg::compare_limit_off, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      for (int c = 1; c < 8; c++) begin
        wr(pmt_pkg::ctrl_status_off, ctl(2'(s), 3'(c)));
        wait_tgl;
        t0 = cyc;
        wait_tgl;
        chk("tick period", 32'(src_per[s] * (s[0] ? dec_div[c - 1] : bin_div[c - 1])), 32'(cyc - t0));
      end
    end
    wr(pmt_pkg::ctrl_status_off, ctl(2'h3, 3'h0));
    repeat (300) @(posedge aclk);
    rchk(pmt_pkg::tick_count_off, 32'h0000_0000);
    tally_and_finish;
  end
  // watchdog against a hung handshake or a silent pin
  initial begin
    repeat (95000) @(posedge aclk);
    failures++;
    tally_and_finish;
  end
endmodule
bind pmt_timer pmt_timer_checker i_pmt_timer_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .match_irq, .toggle_out);
